// ==== rtl/sdm_defines.svh ====
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH

// ============================================================
// register indexes, byte address is four times the index
`define SDM_IDX_REF_DIVIDE      8'h02
`define SDM_IDX_WHOLE_PART      8'h03
`define SDM_IDX_REMAINDER_PART  8'h04
`define SDM_IDX_INDIRECT_ACCESS 8'h05
`define SDM_IDX_MOD_CONFIG      8'h06
`define SDM_IDX_STATUS          8'h0F

// ============================================================
// reset values
`define SDM_RST_REF_DIVIDE      24'h000001
`define SDM_RST_WHOLE_PART      24'h000019
`define SDM_RST_REMAINDER_PART  24'h000000
`define SDM_RST_INDIRECT_ACCESS 24'h000000
`define SDM_RST_MOD_CONFIG      24'h200B4A

// ============================================================
// field positions
`define SDM_REF_RATIO_MSB       13
`define SDM_WHOLE_MSB           18
`define SDM_PACKET_MSB          15

// ============================================================
// modulator start values
`define SDM_SEED_ZERO           24'h000000
`define SDM_SEED_LSB            24'h000001
`define SDM_SEED_PATTERN_A      24'hB29D08
`define SDM_SEED_PATTERN_B      24'h50F1CD

// ============================================================
// self-test reference divider cycle counts
`define SDM_TEST_LEN_0          12'd1032
`define SDM_TEST_LEN_1          12'd2047
`define SDM_TEST_LEN_2          12'd3071
`define SDM_TEST_LEN_3          12'd4095

// ============================================================
// serial link packet length
`define SDM_PACKET_BITS         5'd16

`endif

// ==== rtl/sdm_pkg.sv ====
package sdm_pkg;

    // ============================================================
    // indirect-access packet
    typedef struct packed {
        logic [8:0] oscillator_payload;
        logic [3:0] oscillator_reg_index;
        logic [2:0] oscillator_target_id;
    } sdm_packet_t;

    // ============================================================
    // modulator configuration word
    typedef struct packed {
        logic [1:0] rsv_top;
        logic       auto_clock_config;
        logic [1:0] self_test_length;
        logic       self_test_on;
        logic [1:0] rsv_17_16;
        logic [3:0] rsv_15_12;
        logic       modulator_core_on;
        logic       modulator_clock_choice;
        logic       clock_source;
        logic       reload_start_on_tune;
        logic       modulator_skip;
        logic [2:0] rsv_6_4;
        logic [1:0] order;
        logic [1:0] seed;
    } sdm_mod_cfg_t;

    typedef enum logic [1:0] {
        SDM_ORDER_FIRST  = 2'h0,
        SDM_ORDER_SECOND = 2'h1,
        SDM_ORDER_T1_B   = 2'h2,
        SDM_ORDER_T2_A   = 2'h3
    } sdm_order_t;

    typedef enum logic [1:0] {
        SDM_CLK_REFERENCE = 2'h0,
        SDM_CLK_FEEDBACK  = 2'h1,
        SDM_CLK_AUXILIARY = 2'h2,
        SDM_CLK_DELAYED   = 2'h3
    } sdm_clk_src_t;

    // serial link states, gray along idle, shift, last
    typedef enum logic [1:0] {
        SDM_LINK_IDLE  = 2'b00,
        SDM_LINK_SHIFT = 2'b01,
        SDM_LINK_LAST  = 2'b11
    } sdm_link_state_t;

    typedef enum logic [1:0] {
        SDM_TEST_IDLE = 2'b00,
        SDM_TEST_RUN  = 2'b01,
        SDM_TEST_DONE = 2'b11
    } sdm_test_state_t;

endpackage : sdm_pkg

// ==== rtl/sdm_serial_tx.sv ====
`timescale 1ns/1ps
`include "sdm_defines.svh"

module sdm_serial_tx
    import sdm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic        start_in,
    input  wire sdm_packet_t packet_in,
    output logic             busy_out,
    output logic             data_out,
    output logic             frame_out
);

    sdm_link_state_t state_r, state_nxt;
    logic [15:0]     shift_r, shift_nxt;
    logic [4:0]      count_r, count_nxt;
    logic            data_r, data_nxt;
    logic            frame_r, frame_nxt;

    // ============================================================
    // shifter, one bit per clock, msb first
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        count_nxt = count_r;
        data_nxt  = data_r;
        frame_nxt = frame_r;
        case (state_r)
            SDM_LINK_IDLE: begin
                data_nxt  = 1'b0;
                frame_nxt = 1'b0;
                if (start_in) begin
                    data_nxt  = packet_in[`SDM_PACKET_MSB];
                    shift_nxt = {packet_in[14:0], 1'b0};
                    frame_nxt = 1'b1;
                    count_nxt = `SDM_PACKET_BITS - 5'd1;
                    state_nxt = SDM_LINK_SHIFT;
                end
            end
            SDM_LINK_SHIFT: begin
                data_nxt  = shift_r[15];
                shift_nxt = {shift_r[14:0], 1'b0};
                count_nxt = count_r - 5'd1;
                if (count_r == 5'd1) begin
                    state_nxt = SDM_LINK_LAST;
                end
            end
            SDM_LINK_LAST: begin
                data_nxt  = 1'b0;
                frame_nxt = 1'b0;
                state_nxt = SDM_LINK_IDLE;
            end
            default: begin
                state_nxt = SDM_LINK_IDLE;
                frame_nxt = 1'b0;
                data_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= SDM_LINK_IDLE;
            shift_r <= 16'h0000;
            count_r <= 5'h00;
            data_r  <= 1'b0;
            frame_r <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            count_r <= count_nxt;
            data_r  <= data_nxt;
            frame_r <= frame_nxt;
        end
    end

    assign busy_out  = (state_r != SDM_LINK_IDLE);
    assign data_out  = data_r;
    assign frame_out = frame_r;

endmodule : sdm_serial_tx

// ==== rtl/sdm_self_test.sv ====
`timescale 1ns/1ps
`include "sdm_defines.svh"

module sdm_self_test
    import sdm_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       start_in,
    input  wire logic [1:0] length_in,
    input  wire logic       ref_tick_in,
    output logic            busy_out,
    output logic            done_out
);

    sdm_test_state_t state_r, state_nxt;
    logic [11:0]     count_r, count_nxt;
    logic [11:0]     target_r, target_nxt;

    // ============================================================
    // cycle count for the chosen length
    function automatic logic [11:0] test_length(input logic [1:0] code);
        case (code)
            2'h0:    test_length = `SDM_TEST_LEN_0;
            2'h1:    test_length = `SDM_TEST_LEN_1;
            2'h2:    test_length = `SDM_TEST_LEN_2;
            default: test_length = `SDM_TEST_LEN_3;
        endcase
    endfunction : test_length

    always_comb begin
        state_nxt  = state_r;
        count_nxt  = count_r;
        target_nxt = target_r;
        case (state_r)
            SDM_TEST_IDLE, SDM_TEST_DONE: begin
                if (start_in) begin
                    target_nxt = test_length(length_in);
                    count_nxt  = 12'h000;
                    state_nxt  = SDM_TEST_RUN;
                end
            end
            SDM_TEST_RUN: begin
                if (ref_tick_in) begin
                    count_nxt = count_r + 12'h001;
                    if (count_r + 12'h001 == target_r) begin
                        state_nxt = SDM_TEST_DONE;
                    end
                end
            end
            default: state_nxt = SDM_TEST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r  <= SDM_TEST_IDLE;
            count_r  <= 12'h000;
            target_r <= 12'h000;
        end else if (ce_in) begin
            state_r  <= state_nxt;
            count_r  <= count_nxt;
            target_r <= target_nxt;
        end
    end

    assign busy_out = (state_r == SDM_TEST_RUN);
    assign done_out = (state_r == SDM_TEST_DONE);

endmodule : sdm_self_test

// ==== rtl/sdm_regs.sv ====
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "sdm_defines.svh"

// Contract
// - hold 14-bit reference ratio, gated by buffer
// - remainder word unsigned, fractional mode only
// - indirect packet: target, index, payload fields
// - each indirect write sends packet out
// - indirect read returns last sent packet
// - seed code selects zero, lsb, two patterns
// - seed loads only on tune with reload
// - order field selects modulator topology
// - skip bit drops modulator output from divider
// - skipped modulator still clocked while released
// - clock source bit ignored if 10/21 set
// - clock choice: auxiliary or delayed oscillator; clear gives auxiliary only if 21 set, else bit 9 decides
// - core enable picks calibration trigger write
// - self-test enable starts built-in test
// - test length code sets cycle count
// - calibration rewrites payload only, keeps index and target
// - packet shifted msb first on link
module sdm_regs
    import sdm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // wishbone classic slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    // neighbouring logic, same clock
    input  wire logic        reference_buffer_on_in,
    input  wire logic        modulator_release_in,
    input  wire logic        ref_div_tick_in,
    input  wire logic        cal_payload_valid_in,
    input  wire logic [8:0]  cal_payload_in,
    output logic             cal_payload_ready_out,
    // divider and modulator controls
    output logic [13:0]      ref_ratio_out,
    output logic             ref_ratio_active_out,
    output logic [18:0]      whole_part_out,
    output logic [23:0]      remainder_part_out,
    output logic [23:0]      seed_value_out,
    output logic             seed_load_out,
    output sdm_order_t       modulator_order_out,
    output logic             modulator_output_used_out,
    output logic             modulator_clock_run_out,
    output sdm_clk_src_t     modulator_clock_src_out,
    output logic             auto_clock_config_out,
    output logic             calibration_start_out,
    output logic             self_test_busy_out,
    output logic             self_test_done_out,
    // oscillator serial link
    output logic             oscillator_serial_link_data_out,
    output logic             oscillator_serial_link_frame_out
);

    // ============================================================
    // state
    logic [23:0]  ref_div_r, ref_div_nxt;
    logic [23:0]  whole_r, whole_nxt;
    logic [23:0]  rem_r, rem_nxt;
    sdm_packet_t  pkt_r, pkt_nxt;
    sdm_mod_cfg_t cfg_r, cfg_nxt;
    logic         ack_r, ack_nxt;
    logic [31:0]  rdat_r, rdat_nxt;
    logic         send_r, send_nxt;
    logic         cal_r, cal_nxt;
    logic         seed_ld_r, seed_ld_nxt;
    logic         test_go_r, test_go_nxt;
    logic [23:0]  seed_r, seed_nxt;

    logic         link_busy;
    logic         link_data;
    logic         link_frame;
    logic         test_busy;
    logic         test_done;
    logic         req;
    logic         wr;
    logic         link_free;
    logic [7:0]   idx;
    logic [23:0]  wmask;

    // ============================================================
    // helpers
    function automatic logic [23:0] seed_decode(input logic [1:0] code);
        case (code)
            2'h0:    seed_decode = `SDM_SEED_ZERO;
            2'h1:    seed_decode = `SDM_SEED_LSB;
            2'h2:    seed_decode = `SDM_SEED_PATTERN_A;
            default: seed_decode = `SDM_SEED_PATTERN_B;
        endcase
    endfunction : seed_decode

    function automatic logic [23:0] merge(input logic [23:0] old_v, input logic [23:0] new_v,
                                          input logic [23:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    assign idx       = {2'b00, wb_adr_in[7:2]};
    assign req       = wb_cyc_in && wb_stb_in && !ack_r;
    assign wr        = req && wb_we_in;
    assign link_free = !link_busy && !send_r;
    assign wmask     = {{8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

    // ============================================================
    // bus slave and register writes
    always_comb begin
        ref_div_nxt = ref_div_r;
        whole_nxt   = whole_r;
        rem_nxt     = rem_r;
        pkt_nxt     = pkt_r;
        cfg_nxt     = cfg_r;
        ack_nxt     = 1'b0;
        rdat_nxt    = rdat_r;
        send_nxt    = 1'b0;
        cal_nxt     = 1'b0;
        seed_ld_nxt = 1'b0;
        test_go_nxt = 1'b0;
        seed_nxt    = seed_r;
        if (req && !(wr && idx == `SDM_IDX_INDIRECT_ACCESS && !link_free)) begin
            ack_nxt  = 1'b1;
            rdat_nxt = 32'h00000000;
            case (idx)
                `SDM_IDX_REF_DIVIDE: begin
                    rdat_nxt = {8'h00, ref_div_r};
                    if (wr) begin
                        ref_div_nxt = merge(ref_div_r, wb_dat_in[23:0], wmask);
                    end
                end
                `SDM_IDX_WHOLE_PART: begin
                    rdat_nxt = {8'h00, whole_r};
                    if (wr) begin
                        whole_nxt = merge(whole_r, wb_dat_in[23:0], wmask);
                        cal_nxt   = !cfg_r.modulator_core_on;
                    end
                end
                `SDM_IDX_REMAINDER_PART: begin
                    rdat_nxt = {8'h00, rem_r};
                    if (wr) begin
                        rem_nxt     = merge(rem_r, wb_dat_in[23:0], wmask);
                        cal_nxt     = cfg_r.modulator_core_on;
                        seed_ld_nxt = cfg_r.reload_start_on_tune;
                        if (cfg_r.reload_start_on_tune) begin
                            seed_nxt = seed_decode(cfg_r.seed);
                        end
                    end
                end
                `SDM_IDX_INDIRECT_ACCESS: begin
                    rdat_nxt = {16'h0000, pkt_r};
                    if (wr) begin
                        pkt_nxt  = sdm_packet_t'(16'(merge({8'h00, pkt_r}, wb_dat_in[23:0], wmask)));
                        send_nxt = 1'b1;
                    end
                end
                `SDM_IDX_MOD_CONFIG: begin
                    rdat_nxt = {8'h00, cfg_r};
                    if (wr) begin
                        cfg_nxt     = sdm_mod_cfg_t'(merge(cfg_r, wb_dat_in[23:0], wmask));
                        test_go_nxt = cfg_nxt.self_test_on && !cfg_r.self_test_on;
                    end
                end
                `SDM_IDX_STATUS: begin
                    rdat_nxt = {28'h0000000, test_done, test_busy, link_busy, send_r};
                end
                default: rdat_nxt = 32'h00000000;
            endcase
        end else if (cal_payload_valid_in && link_free && !req) begin
            pkt_nxt.oscillator_payload = cal_payload_in;
            send_nxt                   = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ref_div_r <= `SDM_RST_REF_DIVIDE;
            whole_r   <= `SDM_RST_WHOLE_PART;
            rem_r     <= `SDM_RST_REMAINDER_PART;
            pkt_r     <= sdm_packet_t'(16'(`SDM_RST_INDIRECT_ACCESS));
            cfg_r     <= sdm_mod_cfg_t'(`SDM_RST_MOD_CONFIG);
            ack_r     <= 1'b0;
            rdat_r    <= 32'h00000000;
            send_r    <= 1'b0;
            cal_r     <= 1'b0;
            seed_ld_r <= 1'b0;
            test_go_r <= 1'b0;
            seed_r    <= 24'h000000;
        end else if (ce_in) begin
            ref_div_r <= ref_div_nxt;
            whole_r   <= whole_nxt;
            rem_r     <= rem_nxt;
            pkt_r     <= pkt_nxt;
            cfg_r     <= cfg_nxt;
            ack_r     <= ack_nxt;
            rdat_r    <= rdat_nxt;
            send_r    <= send_nxt;
            cal_r     <= cal_nxt;
            seed_ld_r <= seed_ld_nxt;
            test_go_r <= test_go_nxt;
            seed_r    <= seed_nxt;
        end
    end

    // ============================================================
    // derived controls, registered
    logic [13:0]  ratio_r, ratio_nxt;
    logic         ratio_on_r, ratio_on_nxt;
    logic [23:0]  frac_r, frac_nxt;
    logic         used_r, used_nxt;
    logic         run_r, run_nxt;
    sdm_clk_src_t src_r, src_nxt;
    sdm_order_t   order_r, order_nxt;

    always_comb begin
        ratio_nxt    = ref_div_r[`SDM_REF_RATIO_MSB:0];
        ratio_on_nxt = reference_buffer_on_in && (ref_div_r[`SDM_REF_RATIO_MSB:0] != 14'h0000);
        used_nxt     = !cfg_r.modulator_skip;
        frac_nxt     = cfg_r.modulator_skip ? 24'h000000 : rem_r;
        run_nxt      = cfg_r.modulator_core_on && modulator_release_in;
        order_nxt    = sdm_order_t'(cfg_r.order);
        if (cfg_r.modulator_clock_choice) begin
            src_nxt = SDM_CLK_DELAYED;
        end else if (cfg_r.auto_clock_config) begin
            src_nxt = SDM_CLK_AUXILIARY;
        end else if (cfg_r.clock_source) begin
            src_nxt = SDM_CLK_FEEDBACK;
        end else begin
            src_nxt = SDM_CLK_REFERENCE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ratio_r    <= 14'h0001;
            ratio_on_r <= 1'b0;
            frac_r     <= 24'h000000;
            used_r     <= 1'b1;
            run_r      <= 1'b0;
            src_r      <= SDM_CLK_AUXILIARY;
            order_r    <= SDM_ORDER_T1_B;
        end else if (ce_in) begin
            ratio_r    <= ratio_nxt;
            ratio_on_r <= ratio_on_nxt;
            frac_r     <= frac_nxt;
            used_r     <= used_nxt;
            run_r      <= run_nxt;
            src_r      <= src_nxt;
            order_r    <= order_nxt;
        end
    end

    // ============================================================
    // serial link and self test
    sdm_serial_tx u_link (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .start_in  (send_r),
        .packet_in (pkt_r),
        .busy_out  (link_busy),
        .data_out  (link_data),
        .frame_out (link_frame)
    );

    sdm_self_test u_test (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .ce_in       (ce_in),
        .start_in    (test_go_r),
        .length_in   (cfg_r.self_test_length),
        .ref_tick_in (ref_div_tick_in),
        .busy_out    (test_busy),
        .done_out    (test_done)
    );

    // ============================================================
    // outputs, flip-flop driven except payload ready and self-test busy/done, decoded from state
    assign wb_dat_out                       = rdat_r;
    assign wb_ack_out                       = ack_r;
    assign cal_payload_ready_out            = !link_busy && !send_r;
    assign ref_ratio_out                    = ratio_r;
    assign ref_ratio_active_out             = ratio_on_r;
    assign whole_part_out                   = whole_r[`SDM_WHOLE_MSB:0];
    assign remainder_part_out               = frac_r;
    assign seed_value_out                   = seed_r;
    assign seed_load_out                    = seed_ld_r;
    assign modulator_order_out              = order_r;
    assign modulator_output_used_out        = used_r;
    assign modulator_clock_run_out          = run_r;
    assign modulator_clock_src_out          = src_r;
    assign auto_clock_config_out            = cfg_r.auto_clock_config;
    assign calibration_start_out            = cal_r;
    assign self_test_busy_out               = test_busy;
    assign self_test_done_out               = test_done;
    assign oscillator_serial_link_data_out  = link_data;
    assign oscillator_serial_link_frame_out = link_frame;

endmodule : sdm_regs

// ==== tb/sdm_regs_chk.sv ====
`timescale 1ns/1ps
module sdm_regs_chk (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        reference_buffer_on_in,
    input wire logic        modulator_release_in,
    input wire logic        ref_ratio_active_out,
    input wire logic        modulator_clock_run_out,
    input wire logic        seed_load_out,
    input wire logic [23:0] seed_value_out,
    input wire logic        oscillator_serial_link_frame_out
);
    // ====================
    // bus, link, ratio gate, clock release and seed checks
    wire logic fr  = oscillator_serial_link_frame_out;
    wire logic wr5 = wb_ack_out && wb_we_in && wb_adr_in[7:2] == 6'h05;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_frame;
        fr[*8] ##1 fr[*8] ##1 !fr;
    endsequence
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in)) else $error("ack unasked");
    a_read_top: assert property (wb_ack_out |-> wb_dat_out[31:24] == 8'h00) else $error("top byte set");
    a_link_send: assert property (wr5 |-> ##[1:2] $rose(fr)) else $error("no send");
    a_frame_len: assert property ($rose(fr) |-> s_frame) else $error("frame length");
    a_ratio_gate: assert property (!reference_buffer_on_in |=> !ref_ratio_active_out)
        else $error("ratio on");
    a_clock_release: assert property (!modulator_release_in |=> !modulator_clock_run_out)
        else $error("run");
    a_seed_codes: assert property (seed_load_out |-> seed_value_out inside {24'h000000, 24'h000001,
        24'hB29D08, 24'h50F1CD}) else $error("seed value");
endmodule : sdm_regs_chk
bind sdm_regs sdm_regs_chk u_chk (.clk_in, .rst_n_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out,
    .reference_buffer_on_in, .modulator_release_in, .ref_ratio_active_out, .modulator_clock_run_out, .seed_load_out,
    .seed_value_out, .oscillator_serial_link_frame_out);

// ==== tb/sdm_osc_rx_model.sv ====
`timescale 1ns/1ps
module sdm_osc_rx_model
    import sdm_pkg::*;
(
    input  wire logic   clk_in,
    input  wire logic   frame_in,
    input  wire logic   data_in,
    output sdm_packet_t pkt_out,
    output logic [7:0]  n_pkt_out
);
    // ====================
    // shift in while framed, decode at frame end
    logic [15:0] sh_r = 16'h0000;
    logic        fr_r = 1'h0;
    logic [7:0]  n_r  = 8'h00;
    assign n_pkt_out = n_r;
    always @(posedge clk_in) begin
        fr_r <= frame_in;
        if (frame_in) sh_r <= {sh_r[14:0], data_in};
        if (fr_r && !frame_in) pkt_out <= sh_r;
        if (fr_r && !frame_in) n_r <= n_r + 8'h01;
    end
endmodule : sdm_osc_rx_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import sdm_pkg::*;
;
    logic         clk_in = 1'h0, rst_n_in = 1'h0, cyc = 1'h0, we = 1'h0, buf_on = 1'h1, rel = 1'h1;
    logic         tick = 1'h0, cv = 1'h0, ack, rdy, act, used, run, done, fr, sd, cs;
    logic [7:0]   adr = 8'h00, npk;
    logic [8:0]   cp = 9'h000;
    logic [13:0]  rr;
    logic [18:0]  wh;
    logic [23:0]  sv, fq;
    logic [31:0]  dw = 32'h0, dr, rd;
    sdm_packet_t  pkt;
    sdm_clk_src_t src;
    sdm_order_t   od;
    logic [23:0]  seeds [4] = '{24'h000000, 24'h000001, 24'hB29D08, 24'h50F1CD};
    logic [23:0]  rst_v [5] = '{24'h000001, 24'h000019, 24'h000000, 24'h000000, 24'h200B4A};
    logic [23:0]  cfg_v [4] = '{24'h200F4A, 24'h000B4A, 24'h00094A, 24'h200BC6};
    logic [2:0]   exp_v [4] = '{3'h7, 3'h3, 3'h1, 3'h4};
    int           n_mismatch = 0, n_checks = 0, n_cal = 0;
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) tick <= ~tick;
    always @(posedge clk_in) if (cs === 1'h1) n_cal <= n_cal + 1;
    sdm_regs dut (.clk_in, .rst_n_in, .ce_in(1'h1), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hF), .wb_dat_in(dw), .wb_dat_out(dr), .wb_ack_out(ack), .reference_buffer_on_in(buf_on),
        .modulator_release_in(rel), .ref_div_tick_in(tick), .cal_payload_valid_in(cv), .cal_payload_in(cp),
        .cal_payload_ready_out(rdy), .ref_ratio_out(rr), .ref_ratio_active_out(act), .whole_part_out(wh),
        .remainder_part_out(fq), .seed_value_out(sv), .seed_load_out(), .modulator_order_out(od),
        .modulator_output_used_out(used), .modulator_clock_run_out(run), .modulator_clock_src_out(src),
        .auto_clock_config_out(), .calibration_start_out(cs), .self_test_busy_out(), .self_test_done_out(done),
        .oscillator_serial_link_data_out(sd), .oscillator_serial_link_frame_out(fr));
    sdm_osc_rx_model osc (.clk_in, .frame_in(fr), .data_in(sd), .pkt_out(pkt), .n_pkt_out(npk));
    // ====================
    // tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) n_mismatch++;
        if (s !== e) $display("Error %0t: saw %h expected %h", $time, s, e);
    endtask : chk
    task end_of_test;
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task tmo;
        n_mismatch++;
        $display("Error %0t: timeout", $time);
        end_of_test();
    endtask : tmo
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        dw <= d;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_in);
            if (ack === 1'h1) break;
        end
        if (ack !== 1'h1) tmo();
        rd = dr;
        cyc <= 1'h0;
        @(posedge clk_in);
    endtask : wb
    task automatic wp(input logic [7:0] n);
        for (int k = 0; k < 60 && npk !== n; k++) @(posedge clk_in);
        if (npk !== n) tmo();
    endtask : wp
    // ====================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'h1;
        for (int j = 0; j < 5; j++) begin
            wb(1'h0, 8'(j * 4 + 8), 32'h0);
            chk(rd, {8'h00, rst_v[j]});
        end
        chk(src, SDM_CLK_AUXILIARY);
        wb(1'h1, 8'h08, 32'h3FFF);
        wb(1'h1, 8'h20, 32'hFFFFFFFF);
        wb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'h3FFF);
        chk({act, rr}, {1'h1, 14'h3FFF});
        buf_on <= 1'h0;
        repeat (3) @(posedge clk_in);
        chk(act, 1'h0);
        buf_on <= 1'h1;
        for (int j = 1; j < 5; j++) begin
            wb(1'h1, 8'h18, {8'h00, 24'h200B48 | 24'(j % 4)});
            chk(sv, seeds[j - 1]);
            wb(1'h1, 8'h10, 32'hFFFFFF);
            chk(sv, seeds[j % 4]);
        end
        wb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'hFFFFFF);
        wb(1'h1, 8'h18, 32'h200A49);
        wb(1'h1, 8'h10, 32'h1);
        chk(sv, seeds[0]);
        for (int j = 0; j < 4; j++) begin
            wb(1'h1, 8'h18, {8'h00, cfg_v[j]});
            chk({src, used, run}, {exp_v[j], 1'h1});
        end
        chk(od, SDM_ORDER_SECOND);
        chk(fq, 24'h0);
        wb(1'h1, 8'h0C, 32'h14);
        chk(wh, 19'h14);
        chk(n_cal, 5);
        rel <= 1'h0;
        repeat (3) @(posedge clk_in);
        chk(run, 1'h0);
        rel <= 1'h1;
        wb(1'h1, 8'h14, 32'hABCD);
        wp(8'h01);
        chk(pkt, 16'hABCD);
        chk(pkt.oscillator_payload, 9'h157);
        wb(1'h1, 8'h14, 32'h1235);
        wb(1'h1, 8'h14, 32'h0003);
        wp(8'h03);
        chk(pkt, 16'h0003);
        cp <= 9'h1FF;
        cv <= 1'h1;
        for (int k = 0; k < 60; k++) begin
            @(posedge clk_in);
            if (rdy === 1'h1) break;
        end
        if (rdy !== 1'h1) tmo();
        cv <= 1'h0;
        wp(8'h04);
        chk(pkt, 16'hFF83);
        wb(1'h0, 8'h14, 32'h0);
        chk(rd, 32'hFF83);
        wb(1'h1, 8'h18, 32'h240B4A);
        chk(fq, 24'h1);
        repeat (2000) @(posedge clk_in);
        chk(done, 1'h0);
        repeat (150) @(posedge clk_in);
        chk(done, 1'h1);
        end_of_test();
    end
endmodule : tb_top
